// >>> hdl/ata_cmd_pkg.sv
// Purpose: shared constants and types for the task-file command executor
// Assumes: 32-bit ahb-lite register bus, one clock
// Notes:   offsets are byte addresses of aligned words
package ata_cmd_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_TASK    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_ERROR   = 8'h0c;
  localparam logic [7:0] OFS_CONFIG  = 8'h10;
  localparam logic [7:0] OFS_DATA    = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h1c;
  localparam logic [7:0] OFS_FMT     = 8'h20;

  // opcodes
  localparam logic [7:0] OP_DIAG     = 8'h90;
  localparam logic [7:0] OP_FLUSH    = 8'he7;
  localparam logic [7:0] OP_FORMAT   = 8'h50;
  localparam logic [7:0] OP_IDENTIFY = 8'hec;

  // diagnostic codes
  localparam logic [7:0] DIAG_OK        = 8'h01;
  localparam logic [7:0] DIAG_FORMATTER = 8'h02;
  localparam logic [7:0] DIAG_BUFFER    = 8'h03;
  localparam logic [7:0] DIAG_ECC       = 8'h04;
  localparam logic [7:0] DIAG_CPU       = 8'h05;
  localparam logic [3:0] DIAG_SLAVE_HI  = 4'h8;

  // status bits
  localparam int ST_ERR   = 0;
  localparam int ST_DRQ   = 3;
  localparam int ST_SEEK  = 4;
  localparam int ST_RDY   = 6;
  localparam int ST_BUSY  = 7;
  localparam logic [7:0] ERR_ABORT = 8'h04;

  // drive/head field positions
  localparam int DH_DRV = 4;
  localparam int DH_LBA = 6;

  // irq event bit positions
  localparam int EV_DONE = 0;
  localparam int EV_DRQ  = 1;

  localparam int SECTOR_WORDS = 128;   // 512 bytes as 32-bit words
  localparam int SELFTEST_CYCLES = 16;
  localparam logic [8:0] FULL_COUNT = 9'h100;
  localparam logic [7:0] STATUS_RESET = 8'h50;

  typedef struct packed {
    logic [7:0] drive_head;
    logic [7:0] cyl_high;
    logic [7:0] cyl_low;
    logic [7:0] sec_count;
  } task_file_t;

  typedef struct packed {
    logic [27:0] start_addr;
    logic [8:0]  count;
    logic        lba;
  } format_req_t;

endpackage

// >>> hdl/self_test.sv
// Purpose: built-in self test sequencer returning a diagnostic code
// Assumes: fault inputs are synchronous levels
// Notes:   checks run in a fixed priority, lowest code wins
module self_test (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       start_i,
  input  wire logic [3:0] fault_i,
  // result
  output logic            done_o,
  output logic [7:0]      code_o
);
  logic [4:0] cnt_reg;
  logic       run_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 5'h00;
      run_reg <= 1'b0;
    end else if (start_i) begin
      cnt_reg <= 5'h00;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      if (cnt_reg == 5'(ata_cmd_pkg::SELFTEST_CYCLES - 1)) begin
        run_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      code_o <= 8'h00;
    end else begin
      done_o <= run_reg && cnt_reg == 5'(ata_cmd_pkg::SELFTEST_CYCLES - 1);
      if (fault_i[0]) begin
        code_o <= ata_cmd_pkg::DIAG_FORMATTER;
      end else if (fault_i[1]) begin
        code_o <= ata_cmd_pkg::DIAG_BUFFER;
      end else if (fault_i[2]) begin
        code_o <= ata_cmd_pkg::DIAG_ECC;
      end else if (fault_i[3]) begin
        code_o <= ata_cmd_pkg::DIAG_CPU;
      end else begin
        code_o <= ata_cmd_pkg::DIAG_OK;
      end
    end
  end
endmodule

// >>> hdl/ata_cmd_exec.sv
// Purpose: executes diagnostic, flush, format and identify commands
// Assumes: ahb-lite slave, single word transfers, always OKAY
// Notes:   data port moves one 32-bit word per access, 128 per sector
module ata_cmd_exec #(
  parameter bit       FLUSH_SUPPORTED = 1'b1,
  parameter bit [7:0] FILL_PATTERN    = 8'hff
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // configuration straps and peer (from pins)
  input  wire logic        ide_mode_i,
  input  wire logic        is_slave_i,
  input  wire logic        slave_fail_i,
  input  wire logic [3:0]  slave_code_i,
  // media side
  input  wire logic [3:0]  fault_i,
  input  wire logic        cache_dirty_i,
  input  wire logic        media_done_i,
  output logic             cache_flush_o,
  output logic             format_start_o,
  output ata_cmd_pkg::format_req_t format_req_o,
  output logic [7:0]       fill_pattern_o,
  // interrupt
  output logic             irq_o
);
  typedef enum logic [2:0] {
    IDLE, DIAG, FLUSH, FMT_DATA, FMT_MEDIA, IDENT, DONE
  } state_t;

  state_t                  state_reg;
  ata_cmd_pkg::task_file_t task_reg;
  logic [7:0]              status_reg;
  logic [7:0]              error_reg;
  logic [1:0]              irq_st_reg;
  logic [1:0]              irq_msk_reg;
  logic [6:0]              word_reg;
  logic                    abort_reg;
  logic [7:0]              diag_code;
  logic                    diag_done;
  logic                    diag_start;
  logic                    ev_done;
  logic                    ev_drq;

  // pin synchronisers
  logic [1:0] ide_s, slv_s, sfail_s, dirty_s, mdone_s;
  logic [3:0] scode_s1, scode_s2, fault_s1, fault_s2;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ide_s    <= 2'b00;
      slv_s    <= 2'b00;
      sfail_s  <= 2'b00;
      dirty_s  <= 2'b00;
      mdone_s  <= 2'b00;
      scode_s1 <= 4'h0;
      scode_s2 <= 4'h0;
      fault_s1 <= 4'h0;
      fault_s2 <= 4'h0;
    end else begin
      ide_s    <= {ide_s[0], ide_mode_i};
      slv_s    <= {slv_s[0], is_slave_i};
      sfail_s  <= {sfail_s[0], slave_fail_i};
      dirty_s  <= {dirty_s[0], cache_dirty_i};
      mdone_s  <= {mdone_s[0], media_done_i};
      scode_s1 <= slave_code_i;
      scode_s2 <= scode_s1;
      fault_s1 <= fault_i;
      fault_s2 <= fault_s1;
    end
  end

  // ahb address phase capture
  logic       ph_valid_reg;
  logic       ph_write_reg;
  logic [7:0] ph_addr_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end else if (hready_i) begin
      ph_valid_reg <= hsel_i && htrans_i[1];
      ph_write_reg <= hwrite_i;
      ph_addr_reg  <= haddr_i[7:0];
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  logic wr_cmd, wr_task, wr_data, rd_data, wr_irq_st, wr_irq_msk, wr_cfg;
  assign wr_cmd     = ph_valid_reg && ph_write_reg
                      && ph_addr_reg == ata_cmd_pkg::OFS_CMD;
  assign wr_task    = ph_valid_reg && ph_write_reg
                      && ph_addr_reg == ata_cmd_pkg::OFS_TASK;
  assign wr_data    = ph_valid_reg && ph_write_reg
                      && ph_addr_reg == ata_cmd_pkg::OFS_DATA;
  assign rd_data    = ph_valid_reg && !ph_write_reg
                      && ph_addr_reg == ata_cmd_pkg::OFS_DATA;
  assign wr_irq_st  = ph_valid_reg && ph_write_reg
                      && ph_addr_reg == ata_cmd_pkg::OFS_IRQ_ST;
  assign wr_irq_msk = ph_valid_reg && ph_write_reg
                      && ph_addr_reg == ata_cmd_pkg::OFS_IRQ_MSK;
  assign wr_cfg     = ph_valid_reg && ph_write_reg
                      && ph_addr_reg == ata_cmd_pkg::OFS_CONFIG;

  // software-set drive number of this card in card mode
  logic drive_id_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_id_reg <= 1'b0;
    end else if (wr_cfg) begin
      drive_id_reg <= hwdata_i[0];
    end
  end

  logic selected, cmd_ok;
  assign selected = task_reg.drive_head[ata_cmd_pkg::DH_DRV] == drive_id_reg;
  // commands are refused while busy
  assign cmd_ok   = wr_cmd && state_reg == IDLE;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      task_reg <= '0;
    end else if (wr_task && state_reg == IDLE) begin
      task_reg <= hwdata_i;
    end
  end

  assign diag_start = cmd_ok && hwdata_i[7:0] == ata_cmd_pkg::OP_DIAG
                      && (ide_s[1] || selected);

  self_test u_self_test (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (diag_start),
    .fault_i (fault_s2),
    .done_o  (diag_done),
    .code_o  (diag_code)
  );

  // command sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= IDLE;
      word_reg  <= 7'h00;
      abort_reg <= 1'b0;
    end else begin
      case (state_reg)
        IDLE: begin
          word_reg  <= 7'h00;
          if (cmd_ok) begin
            abort_reg <= 1'b0;
            // only opcode matters here; drive bit and ide mode gate the diagnostic only
            if (diag_start) begin
              state_reg <= DIAG;
            end else if (hwdata_i[7:0] == ata_cmd_pkg::OP_FLUSH) begin
              if (FLUSH_SUPPORTED) begin
                state_reg <= FLUSH;
              end else begin
                abort_reg <= 1'b1;
                state_reg <= DONE;
              end
            end else if (hwdata_i[7:0] == ata_cmd_pkg::OP_FORMAT) begin
              state_reg <= FMT_DATA;
            end else if (hwdata_i[7:0] == ata_cmd_pkg::OP_IDENTIFY) begin
              state_reg <= IDENT;
            end else if (hwdata_i[7:0] != ata_cmd_pkg::OP_DIAG) begin
              abort_reg <= 1'b1;
              state_reg <= DONE;
            end
          end
        end
        DIAG: if (diag_done) state_reg <= DONE;
        FLUSH: begin
          // complete only once the cache is clean
          if (!dirty_s[1] && mdone_s[1]) state_reg <= DONE;
        end
        FMT_DATA: begin
          if (wr_data) begin
            // payload is dropped
            word_reg <= word_reg + 7'h01;
            if (word_reg == 7'(ata_cmd_pkg::SECTOR_WORDS - 1)) begin
              state_reg <= FMT_MEDIA;
            end
          end
        end
        FMT_MEDIA: if (mdone_s[1]) state_reg <= DONE;
        IDENT: begin
          if (rd_data) begin
            word_reg <= word_reg + 7'h01;
            if (word_reg == 7'(ata_cmd_pkg::SECTOR_WORDS - 1)) begin
              state_reg <= DONE;
            end
          end
        end
        DONE: state_reg <= IDLE;
        default: state_reg <= IDLE;
      endcase
    end
  end

  assign cache_flush_o  = state_reg == FLUSH;
  assign fill_pattern_o = FILL_PATTERN;
  assign ev_done        = state_reg == DONE;
  assign ev_drq         = cmd_ok && (hwdata_i[7:0] == ata_cmd_pkg::OP_FORMAT
                          || hwdata_i[7:0] == ata_cmd_pkg::OP_IDENTIFY);

  // format request, launched once the sector has been taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      format_start_o <= 1'b0;
      format_req_o   <= '0;
    end else begin
      format_start_o <= state_reg == FMT_DATA && wr_data
                        && word_reg == 7'(ata_cmd_pkg::SECTOR_WORDS - 1);
      if (cmd_ok && hwdata_i[7:0] == ata_cmd_pkg::OP_FORMAT) begin
        format_req_o.start_addr <= {task_reg.drive_head[3:0],
                                    task_reg.cyl_high,
                                    task_reg.cyl_low, 8'h00};
        format_req_o.lba <= task_reg.drive_head[ata_cmd_pkg::DH_LBA];
        format_req_o.count <= (task_reg.sec_count == 8'h00)
                              ? ata_cmd_pkg::FULL_COUNT
                              : {1'b0, task_reg.sec_count};
      end
    end
  end

  // status and error registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= ata_cmd_pkg::STATUS_RESET;
      error_reg  <= 8'h00;
    end else begin
      if (cmd_ok && (diag_start
                     || hwdata_i[7:0] != ata_cmd_pkg::OP_DIAG)) begin
        status_reg[ata_cmd_pkg::ST_BUSY] <= 1'b1;
        status_reg[ata_cmd_pkg::ST_ERR]  <= 1'b0;
      end
      // busy again while the media writes the track
      if (state_reg == FMT_DATA || state_reg == IDENT
          || state_reg == FMT_MEDIA) begin
        status_reg[ata_cmd_pkg::ST_BUSY] <= state_reg == FMT_MEDIA;
        status_reg[ata_cmd_pkg::ST_DRQ]  <= state_reg != FMT_MEDIA;
      end
      if (ev_done) begin
        status_reg[ata_cmd_pkg::ST_BUSY] <= 1'b0;
        status_reg[ata_cmd_pkg::ST_DRQ]  <= 1'b0;
        status_reg[ata_cmd_pkg::ST_RDY]  <= 1'b1;
        status_reg[ata_cmd_pkg::ST_SEEK] <= 1'b1;
        status_reg[ata_cmd_pkg::ST_ERR]  <= abort_reg;
        if (abort_reg) error_reg <= ata_cmd_pkg::ERR_ABORT;
      end
      if (diag_done) begin
        if (ide_s[1] && !slv_s[1] && sfail_s[1]) begin
          error_reg <= {ata_cmd_pkg::DIAG_SLAVE_HI, scode_s2};
        end else begin
          error_reg <= diag_code;
        end
      end
    end
  end

  // sticky interrupt status, set wins over write-one-clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_st_reg  <= 2'b00;
      irq_msk_reg <= 2'b00;
    end else begin
      irq_st_reg <= (irq_st_reg & ~(wr_irq_st ? hwdata_i[1:0] : 2'b00))
                    | {ev_drq, ev_done};
      if (wr_irq_msk) irq_msk_reg <= hwdata_i[1:0];
    end
  end
  assign irq_o = |(irq_st_reg & irq_msk_reg);

  // identify word: only word 0 is nonzero, rest reserved
  logic [31:0] ident_word;
  always_comb begin
    ident_word = 32'h0000_0000;
    if (word_reg == 7'h00) begin
      ident_word = ide_s[1] ? 32'h0000_045a : 32'h0000_848a;
    end
  end

  // read data mux
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (ph_valid_reg && !ph_write_reg) begin
      if (ph_addr_reg == ata_cmd_pkg::OFS_TASK) begin
        hrdata_o = task_reg;
      end else if (ph_addr_reg == ata_cmd_pkg::OFS_STATUS) begin
        hrdata_o = {24'h000000, status_reg};
      end else if (ph_addr_reg == ata_cmd_pkg::OFS_ERROR) begin
        hrdata_o = {24'h000000, error_reg};
      end else if (ph_addr_reg == ata_cmd_pkg::OFS_CONFIG) begin
        hrdata_o = {31'h0000_0000, drive_id_reg};
      end else if (ph_addr_reg == ata_cmd_pkg::OFS_DATA) begin
        hrdata_o = (state_reg == IDENT) ? ident_word : 32'h0000_0000;
      end else if (ph_addr_reg == ata_cmd_pkg::OFS_IRQ_ST) begin
        hrdata_o = {30'h0000_0000, irq_st_reg};
      end else if (ph_addr_reg == ata_cmd_pkg::OFS_IRQ_MSK) begin
        hrdata_o = {30'h0000_0000, irq_msk_reg};
      end else if (ph_addr_reg == ata_cmd_pkg::OFS_FMT) begin
        hrdata_o = {23'h000000, format_req_o.count};
      end
    end
  end
endmodule

// >>> bench/ata_cmd_exec_asserts.sv
// Purpose: port-level checks on the task-file command executor
// Assumes: zero-wait slave, hready_i tied to hreadyout_o by the bench
// Notes:   mask and unmapped-read trackers are rebuilt from bus traffic
module ata_cmd_exec_checker #(
  parameter bit       FLUSH_SUPPORTED = 1'b1,
  parameter bit [7:0] FILL_PATTERN    = 8'hff
) (
  // clock and reset
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  // ahb-lite
  input wire logic                     hsel_i,
  input wire logic [31:0]              haddr_i,
  input wire logic [1:0]               htrans_i,
  input wire logic                     hwrite_i,
  input wire logic [31:0]              hwdata_i,
  input wire logic                     hready_i,
  input wire logic [31:0]              hrdata_o,
  input wire logic                     hreadyout_o,
  input wire logic                     hresp_o,
  // media side and interrupt
  input wire logic                     cache_dirty_i,
  input wire logic                     cache_flush_o,
  input wire logic                     format_start_o,
  input wire ata_cmd_pkg::format_req_t format_req_o,
  input wire logic [7:0]               fill_pattern_o,
  input wire logic                     irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic unm_q;
  logic msk_wr_q;
  logic mzero;
  assign take = hsel_i && htrans_i[1] && hready_i;
  // mask resets to zero but is not tracked until software writes it, so mzero starts low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      unm_q    <= 1'b0;
      msk_wr_q <= 1'b0;
      mzero    <= 1'b0;
    end else begin
      unm_q    <= take && !hwrite_i && haddr_i[31:8] == 24'h0 &&
                  haddr_i[7:0] > ata_cmd_pkg::OFS_FMT;
      msk_wr_q <= take && hwrite_i &&
                  haddr_i == {24'h0, ata_cmd_pkg::OFS_IRQ_MSK};
      if (msk_wr_q) begin
        mzero <= hwdata_i == 32'h0;
      end
    end
  end
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("slave response not okay");
  a_zero_wait: assert property (hreadyout_o == 1'b1)
    else $error("slave inserted a wait state");
  a_fill_value: assert property (fill_pattern_o == FILL_PATTERN)
    else $error("fill pattern differs from parameter");
  a_start_pulse: assert property (format_start_o |=> !format_start_o)
    else $error("format start longer than one cycle");
  a_count_range: assert property (format_start_o && format_req_o.lba |->
    format_req_o.count >= 9'h001 && format_req_o.count <= 9'h100)
    else $error("format count out of range");
  a_flush_holds: assert property (cache_flush_o && cache_dirty_i
    |=> cache_flush_o)
    else $error("flush ended while cache dirty");
  a_no_flush: assert property (!FLUSH_SUPPORTED |-> !cache_flush_o)
    else $error("flush started without support");
  a_unmapped_zero: assert property (unm_q |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (mzero && $past(mzero) |-> !irq_o)
    else $error("interrupt high while fully masked");
endmodule
bind ata_cmd_exec ata_cmd_exec_checker #(
  .FLUSH_SUPPORTED(FLUSH_SUPPORTED), .FILL_PATTERN(FILL_PATTERN)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .cache_dirty_i(cache_dirty_i),
  .cache_flush_o(cache_flush_o), .format_start_o(format_start_o),
  .format_req_o(format_req_o), .fill_pattern_o(fill_pattern_o),
  .irq_o(irq_o)
);

// >>> bench/media_model.sv
// Purpose: behavioural media and write cache behind the executor
// Assumes: one request at a time, delay set by the bench
// Notes:   done is only a short level, so a stale done is never left up
module media_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // requests
  input  wire logic       flush_i,
  input  wire logic       start_i,
  input  wire logic       dirty_set_i,
  input  wire logic [7:0] delay_i,
  // answers
  output logic            dirty_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       flush_q;
  logic       busy;
  logic [7:0] cnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flush_q <= 1'b0;
      busy    <= 1'b0;
      cnt     <= 8'h00;
      dirty_o <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      flush_q <= flush_i;
      if (dirty_set_i) begin
        dirty_o <= 1'b1;
      end
      if (start_i || (flush_i && !flush_q)) begin
        busy   <= 1'b1;
        done_o <= 1'b0;
        cnt    <= delay_i;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        busy    <= 1'b0;
        done_o  <= 1'b1;
        dirty_o <= 1'b0;
        cnt     <= 8'h08;
      end else begin
        done_o <= 1'b0;
      end
    end
  end
endmodule

// >>> bench/testbench.sv
// Purpose: register-level test of the command executor
// Assumes: zero-wait ahb-lite slave, one word per access
// Notes:   every wait is bounded and a timeout counts as a mismatch
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, st;
  logic [1:0] htrans_i = 2'b00;
  logic [2:0] hsize_i = 3'h2;
  logic ide_mode_i = 1'b0, is_slave_i = 1'b0, slave_fail_i = 1'b0;
  logic [3:0] slave_code_i = 4'h0, fault_i = 4'h0;
  logic dirty_set = 1'b0, cache_dirty_i, media_done_i, cache_flush_o;
  logic [7:0] delay = 8'h04, fill_pattern_o;
  logic hreadyout_o, hresp_o, format_start_o, irq_o;
  ata_cmd_pkg::format_req_t format_req_o, req;
  int fail_count = 0, comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  // sel2 routes the bus to a second executor built without flush support
  logic sel2 = 1'b0, rdy2, hrdy;
  logic [31:0] hrdata2;
  assign hrdy = sel2 ? rdy2 : hreadyout_o;
  ata_cmd_exec uut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i && !sel2),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hrdy),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .ide_mode_i(ide_mode_i), .is_slave_i(is_slave_i),
    .slave_fail_i(slave_fail_i), .slave_code_i(slave_code_i),
    .fault_i(fault_i), .cache_dirty_i(cache_dirty_i),
    .media_done_i(media_done_i), .cache_flush_o(cache_flush_o),
    .format_start_o(format_start_o), .format_req_o(format_req_o),
    .fill_pattern_o(fill_pattern_o), .irq_o(irq_o));
  media_model u_media (.clk_i(clk_i), .rst_i(rst_i),
    .flush_i(cache_flush_o), .start_i(format_start_o),
    .dirty_set_i(dirty_set), .delay_i(delay), .dirty_o(cache_dirty_i),
    .done_o(media_done_i));
  ata_cmd_exec #(.FLUSH_SUPPORTED(1'b0)) uut_noflush (.clk_i(clk_i),
    .rst_i(rst_i), .hsel_i(hsel_i && sel2), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hrdy), .hrdata_o(hrdata2),
    .hreadyout_o(rdy2), .hresp_o(), .ide_mode_i(1'b0),
    .is_slave_i(1'b0), .slave_fail_i(1'b0), .slave_code_i(4'h0),
    .fault_i(4'h0), .cache_dirty_i(1'b0), .media_done_i(1'b0),
    .cache_flush_o(), .format_start_o(), .format_req_o(),
    .fill_pattern_o(), .irq_o());
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_up(input string what);
    fail_count++;
    $display("Error %s timed out", what);
    final_report();
  endtask
  // one single transfer: address phase, then data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    int n;
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'b10;
    hwrite_i <= w;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) give_up("address phase");
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) give_up("data phase");
    rd = sel2 ? hrdata2 : hrdata_o;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(what, v, e);
  endtask
  task wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin ahb(1'b0, ata_cmd_pkg::OFS_STATUS, 32'h0, st); n++; end
    while (st[b] !== v && n < 300);
    if (n >= 300) give_up("status wait");
  endtask
  task run_cmd(input logic [31:0] tf, input logic [7:0] op);
    wr(ata_cmd_pkg::OFS_TASK, tf);
    wr(ata_cmd_pkg::OFS_CMD, {24'h0, op});
  endtask
  // busy must be seen set, then clear, then the code and the done event
  task diag(input logic [31:0] tf, input logic [7:0] code);
    run_cmd(tf, ata_cmd_pkg::OP_DIAG);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b1);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b0);
    rdchk("error", ata_cmd_pkg::OFS_ERROR, {24'h0, code});
    rdchk("irq status", ata_cmd_pkg::OFS_IRQ_ST, 32'h1);
    wr(ata_cmd_pkg::OFS_IRQ_ST, 32'h3);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("status", ata_cmd_pkg::OFS_STATUS, 32'h50);
    rdchk("error", ata_cmd_pkg::OFS_ERROR, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    check("irq", {31'h0, irq_o}, 32'h0);
    wr(ata_cmd_pkg::OFS_IRQ_MSK, 32'h3);
    diag(32'h2fff_ffff, ata_cmd_pkg::DIAG_OK);
    for (int i = 0; i < 4; i++) begin
      fault_i <= 4'h1 << i;
      diag(32'h0, 8'h02 + 8'(i));
    end
    fault_i <= 4'h0;
    run_cmd(32'h1000_0000, ata_cmd_pkg::OP_DIAG);
    rdchk("unselected status", ata_cmd_pkg::OFS_STATUS, 32'h50);
    rdchk("unselected irq", ata_cmd_pkg::OFS_IRQ_ST, 32'h0);
    ide_mode_i <= 1'b1;
    slave_fail_i <= 1'b1;
    slave_code_i <= 4'h3;
    repeat (4) @(posedge clk_i);
    diag(32'h1000_0000, 8'h83);
    slave_fail_i <= 1'b0;
    dirty_set <= 1'b1;
    delay <= 8'd40;
    @(posedge clk_i);
    dirty_set <= 1'b0;
    run_cmd(32'h0, ata_cmd_pkg::OP_FLUSH);
    // the flush state starts at the edge that ends the command write
    @(posedge clk_i);
    check("flushing", {31'h0, cache_flush_o}, 32'h1);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b0);
    check("dirty", {31'h0, cache_dirty_i}, 32'h0);
    check("flush status", st & 32'hd9, 32'h50);
    wr(ata_cmd_pkg::OFS_IRQ_ST, 32'h3);
    // format is issued once only, as a legacy host would
    run_cmd(32'h4a12_3400, ata_cmd_pkg::OP_FORMAT);
    wait_st(ata_cmd_pkg::ST_DRQ, 1'b1);
    for (int i = 0; i < ata_cmd_pkg::SECTOR_WORDS; i++)
      wr(ata_cmd_pkg::OFS_DATA, 32'h5a5a_0000 + i);
    for (int n = 0; n < 100 && format_start_o !== 1'b1; n++)
      @(posedge clk_i);
    if (format_start_o !== 1'b1) give_up("format start");
    req = format_req_o;
    check("start", {4'h0, req.start_addr[27:8], 8'h0}, 32'ha123400);
    check("count", {23'h0, req.count}, 32'h100);
    check("lba", {31'h0, req.lba}, 32'h1);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b0);
    check("format drq", {31'h0, st[ata_cmd_pkg::ST_DRQ]}, 32'h0);
    wr(ata_cmd_pkg::OFS_IRQ_ST, 32'h3);
    run_cmd(32'h0, ata_cmd_pkg::OP_IDENTIFY);
    wait_st(ata_cmd_pkg::ST_DRQ, 1'b1);
    for (int i = 0; i < ata_cmd_pkg::SECTOR_WORDS; i++)
      rdchk("identify", ata_cmd_pkg::OFS_DATA, i == 0 ? 32'h45a : 32'h0);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b0);
    wr(ata_cmd_pkg::OFS_IRQ_ST, 32'h3);
    wr(ata_cmd_pkg::OFS_IRQ_MSK, 32'h0);
    run_cmd(32'h0, ata_cmd_pkg::OP_DIAG);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b1);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b0);
    check("masked irq", {31'h0, irq_o}, 32'h0);
    wr(ata_cmd_pkg::OFS_IRQ_MSK, 32'h1);
    repeat (3) @(posedge clk_i);
    check("unmasked irq", {31'h0, irq_o}, 32'h1);
    wr(ata_cmd_pkg::OFS_IRQ_ST, 32'h3);
    repeat (3) @(posedge clk_i);
    check("cleared irq", {31'h0, irq_o}, 32'h0);
    sel2 <= 1'b1;
    run_cmd(32'h0, ata_cmd_pkg::OP_FLUSH);
    wait_st(ata_cmd_pkg::ST_BUSY, 1'b0);
    check("abort err", {31'h0, st[ata_cmd_pkg::ST_ERR]}, 32'h1);
    rdchk("abort code", ata_cmd_pkg::OFS_ERROR,
          {24'h0, ata_cmd_pkg::ERR_ABORT});
    final_report();
  end
endmodule
